/* File: common/dsc_cfg.svh */
// Purpose: constants for the terminal-side serial control block
// Assumes: 25 MHz clock
// Notes:   flow-control and set-ready encodings are plain choices
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH
`define DSC_CLK_HZ            25000000
`define DSC_LAMP_FLASH_MS     100
`define DSC_LAMP_FLASH_CYC    ((`DSC_CLK_HZ / 1000) * `DSC_LAMP_FLASH_MS)
`define DSC_HIGH_RATE_BPS     2400
`define DSC_FLOW_RTSCTS       4'h3
`define DSC_DSR_ALWAYS        1'h0
`define DSC_LEVEL_ON          1'h0
`define DSC_LEVEL_OFF         1'h1
`endif

/* File: common/dsc_pkg.sv */
// Purpose: types for the terminal-side serial control block
// Assumes: nothing
// Notes:   terminal-ready handling mirrors the four usual choices
package dsc_pkg;
	typedef enum logic [1:0] {DSC_DTR_IGNORE, DSC_DTR_CMD, DSC_DTR_HANGUP, DSC_DTR_RESET}
		dsc_dtr_t;
	typedef enum logic [1:0] {DSC_ST_IDLE, DSC_ST_ONLINE, DSC_ST_DISC} dsc_conn_t;
endpackage

/* File: rtl/dsc_sync.sv */
// Purpose: two-flop synchroniser for a bundle of levels
// Assumes: inputs are quasi-static levels
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module dsc_sync #(
	parameter int WIDTH = 4
) (
	input  wire logic             clock,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_dout;

	initial
	begin
		if (WIDTH < 1)
			$error("width too small");
	end

	always_comb
	begin
		next_stage1 = din;
		next_dout   = stage1;
	end

	// idle level of these active-low circuits is high
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			stage1 <= '1;
			dout   <= '1;
		end
		else
		begin
			stage1 <= next_stage1;
			dout   <= next_dout;
		end
	end
endmodule
`default_nettype wire

/* File: rtl/dsc_flasher.sv */
// Purpose: lamp flash stretcher
// Assumes: err pulse may be one cycle
// Notes:   a new error restarts the flash
`timescale 1ns/1ps
`default_nettype none
module dsc_flasher #(
	parameter int unsigned CYCLES = 16
) (
	input  wire logic clock,
	input  wire logic nrst,
	input  wire logic enable,
	input  wire logic err,
	output logic      lit
);
	logic [31:0] count;
	logic [31:0] next_count;
	logic        next_lit;

	initial
	begin
		if (CYCLES < 1)
			$error("flash length must be at least one cycle");
	end

	always_comb
	begin
		next_count = count;
		if (!enable)
			next_count = 32'h0;
		else if (err)
			next_count = 32'(CYCLES);
		else if (count != 32'h0)
			next_count = count - 32'h1;
		next_lit = (next_count != 32'h0);
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			count <= 32'h0;
			lit   <= 1'b0;
		end
		else
		begin
			count <= next_count;
			lit   <= next_lit;
		end
	end
endmodule
`default_nettype wire

/* File: rtl/dsc_serial_ctrl.sv */
// Purpose: terminal-side control circuits, data steering and lamps
// Assumes: inputs synchronous enough for a two-flop sync; single clock
// Notes:   all pins are active low, inverted V.24 levels
//
// Operation
// - transmit data is commands or line data
// - receive data carries responses or line data
// - clear-to-send held ON unless hardware flow while online, or sync mode
// - carrier detect follows carrier unless forced
// - test-mode pin low during tests
// - ring indicate follows ring ON segments
// - rate indicate ON at 2400 bps up
// - terminal-ready ON prepares and holds call
// - terminal-ready OFF disconnects per settings
// - request-to-send ignored in command state
// - request-to-send is flow only when selected
// - remote-loop low requests remote digital loop
// - analog-loop low enters analog loopback
// - auto-answer lamp lit for nonzero ring count
// - test lamp flashes on detected errors
// - terminal-ready lamp follows, or low if ignored
`include "dsc_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dsc_serial_ctrl
	import dsc_pkg::*;
#(
	parameter int unsigned FLASH_CYCLES = `DSC_LAMP_FLASH_CYC,
	parameter int unsigned RATE_W       = 17
) (
	input  wire logic              clock,
	input  wire logic              nrst,
	// terminal-side pins
	input  wire logic              txd_n,
	output logic                   rxd_n,
	output logic                   cts_n,
	output logic                   dsr_n,
	output logic                   line_signal_detect_n,
	output logic                   test_mode_n,
	output logic                   ri_n,
	output logic                   rate_indicate_n,
	input  wire logic              dtr_n,
	input  wire logic              rts_n,
	input  wire logic              remote_loop_req_n,
	input  wire logic              analog_loop_req_n,
	output logic                   autoanswer_lamp_n,
	output logic                   testmode_lamp_n,
	output logic                   terminal_ready_lamp_n,
	// settings
	input  wire logic [3:0]        flow_control_setting,
	input  wire logic              set_ready_setting,
	input  wire logic              carrier_forced_on_setting,
	input  wire logic [1:0]        terminal_ready_handling,
	input  wire logic [3:0]        operating_mode_setting,
	input  wire logic [7:0]        answer_ring_count,
	input  wire logic              sync_mode,
	// modem core side
	input  wire logic              online,
	input  wire logic              resp_data,
	input  wire logic              line_rx_data,
	output logic                   cmd_tx_data,
	output logic                   line_tx_data,
	input  wire logic              carrier_detect,
	input  wire logic              ring_on,
	input  wire logic [RATE_W-1:0] line_rate_bps,
	input  wire logic              high_rate_wanted,
	input  wire logic              data_ready,
	input  wire logic              core_test_active,
	input  wire logic              test_error,
	input  wire logic              host_can_send,
	output logic                   terminal_ready,
	output logic                   host_ready_for_data,
	output logic                   remote_loop_req,
	output logic                   analog_loop_req,
	output logic                   disconnect_req,
	output logic                   reset_req,
	output logic                   cmd_mode_req,
	output logic                   connection_state
);
	localparam logic [RATE_W-1:0] HIGH_RATE = RATE_W'(`DSC_HIGH_RATE_BPS);

	initial
	begin
		if (RATE_W < 12 || RATE_W > 32)
			$error("rate width must hold 2400 and fit 32 bits");
		if (FLASH_CYCLES < 1)
			$error("lamp flash must last at least one cycle");
	end

	function automatic logic on_level(input logic asserted);
		return asserted ? `DSC_LEVEL_ON : `DSC_LEVEL_OFF;
	endfunction

	// pins are inverted circuits: a low level means ON
	function automatic logic is_on(input logic level);
		return (level == `DSC_LEVEL_ON);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// input synchronisation

	logic [3:0] syncIn;
	logic       dtrOn;
	logic       rtsOn;
	logic       remoteOn;
	logic       analogOn;

	dsc_sync #(
		.WIDTH (4)
	) u_sync (
		.clock (clock),
		.nrst  (nrst),
		.din   ({dtr_n, rts_n, remote_loop_req_n, analog_loop_req_n}),
		.dout  (syncIn)
	);

	assign dtrOn    = is_on(syncIn[3]);
	assign rtsOn    = is_on(syncIn[2]);
	assign remoteOn = is_on(syncIn[1]);
	assign analogOn = is_on(syncIn[0]);

	////////////////////////////////////////////////////////////////////////
	// terminal-ready connection state

	dsc_dtr_t  dtrMode;
	dsc_conn_t conn;
	dsc_conn_t next_conn;
	logic      dtrPrev;
	logic      next_dtrPrev;
	logic      dtrFall;
	logic      next_disconnect_req;
	logic      next_reset_req;
	logic      next_cmd_mode_req;

	assign dtrMode = dsc_dtr_t'(terminal_ready_handling);
	assign dtrFall = dtrPrev && !dtrOn;

	always_comb
	begin
		next_conn           = conn;
		next_dtrPrev        = dtrOn;
		next_disconnect_req = 1'b0;
		next_reset_req      = 1'b0;
		next_cmd_mode_req   = 1'b0;
		case (conn)
			DSC_ST_IDLE:
			begin
				if (online && (dtrOn || dtrMode == DSC_DTR_IGNORE))
					next_conn = DSC_ST_ONLINE;
			end
			DSC_ST_ONLINE:
			begin
				// a drop hangs up unless ignored, or taken as a command request under command handling in operating mode 0
				if (dtrFall && dtrMode != DSC_DTR_IGNORE)
				begin
					if (dtrMode == DSC_DTR_CMD && operating_mode_setting == 4'h0)
						next_cmd_mode_req = 1'b1;
					else
					begin
						next_conn           = DSC_ST_DISC;
						next_disconnect_req = 1'b1;
						next_reset_req      = (dtrMode == DSC_DTR_RESET);
					end
				end
				else if (!online)
					next_conn = DSC_ST_IDLE;
			end
			DSC_ST_DISC:
			begin
				if (!online)
					next_conn = DSC_ST_IDLE;
				else
					next_disconnect_req = 1'b1;
			end
			default:
				next_conn = DSC_ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			conn           <= DSC_ST_IDLE;
			dtrPrev        <= 1'b0;
			disconnect_req <= 1'b0;
			reset_req      <= 1'b0;
			cmd_mode_req   <= 1'b0;
		end
		else
		begin
			conn           <= next_conn;
			dtrPrev        <= next_dtrPrev;
			disconnect_req <= next_disconnect_req;
			reset_req      <= next_reset_req;
			cmd_mode_req   <= next_cmd_mode_req;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// test lamp flasher

	logic inTest;
	logic flashLit;

	assign inTest = core_test_active || analogOn || remoteOn;

	dsc_flasher #(
		.CYCLES (FLASH_CYCLES)
	) u_flash (
		.clock  (clock),
		.nrst   (nrst),
		.enable (inTest),
		.err    (test_error),
		.lit    (flashLit)
	);

	////////////////////////////////////////////////////////////////////////
	// pin and core-side outputs

	logic hwFlow;
	logic next_rxd_n;
	logic next_cts_n;
	logic next_dsr_n;
	logic next_line_signal_detect_n_n;
	logic next_tm_n;
	logic next_ri_n;
	logic next_rate_n;
	logic next_aa_n;
	logic next_tmlamp_n;
	logic next_dtrlamp_n;
	logic next_cmd_tx;
	logic next_line_tx;
	logic next_terminal_ready;
	logic next_host_ready;
	logic next_remote;
	logic next_analog;
	logic next_conn_state;

	assign hwFlow = (flow_control_setting == `DSC_FLOW_RTSCTS);

	always_comb
	begin
		next_rxd_n  = online ? line_rx_data : resp_data;
		if (!sync_mode && hwFlow && online)
			next_cts_n = on_level(host_can_send);
		else
			next_cts_n = on_level(sync_mode ? (rtsOn && online) : 1'b1);
		// set-ready OFF tells the terminal to ignore everything but ring
		if (set_ready_setting == `DSC_DSR_ALWAYS)
			next_dsr_n = on_level(1'b1);
		else
			next_dsr_n = on_level(data_ready);
		next_line_signal_detect_n_n = on_level(carrier_forced_on_setting || carrier_detect);
		next_tm_n   = on_level(inTest);
		next_ri_n   = on_level(ring_on);
		next_rate_n = on_level(high_rate_wanted || line_rate_bps >= HIGH_RATE);
		next_aa_n   = on_level(answer_ring_count != 8'h00);
		next_tmlamp_n = on_level(inTest && !flashLit);
		if (dtrMode == DSC_DTR_IGNORE)
			next_dtrlamp_n = `DSC_LEVEL_ON;
		else
			next_dtrlamp_n = on_level(dtrOn);
	end

	////////////////////////////////////////////////////////////////////////
	// core-side outputs

	always_comb
	begin
		// the idle side of the steering rests at mark, so the core sees no start bit
		next_cmd_tx         = online ? 1'b1 : txd_n;
		next_line_tx        = online ? txd_n : 1'b1;
		next_terminal_ready = dtrOn || dtrMode == DSC_DTR_IGNORE;
		// rts only matters online and in hardware flow or sync operation
		next_host_ready     = !online ? 1'b1 :
			((hwFlow || sync_mode) ? rtsOn : 1'b1);
		next_remote         = remoteOn;
		next_analog         = analogOn;
		next_conn_state     = (conn == DSC_ST_ONLINE);
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			cmd_tx_data         <= 1'b1;
			line_tx_data        <= 1'b1;
			terminal_ready      <= 1'b0;
			host_ready_for_data <= 1'b0;
			remote_loop_req     <= 1'b0;
			analog_loop_req     <= 1'b0;
			connection_state    <= 1'b0;
		end
		else
		begin
			cmd_tx_data         <= next_cmd_tx;
			line_tx_data        <= next_line_tx;
			terminal_ready      <= next_terminal_ready;
			host_ready_for_data <= next_host_ready;
			remote_loop_req     <= next_remote;
			analog_loop_req     <= next_analog;
			connection_state    <= next_conn_state;
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			rxd_n                 <= 1'b1;
			cts_n                 <= 1'b1;
			dsr_n                 <= 1'b1;
			line_signal_detect_n  <= 1'b1;
			test_mode_n           <= 1'b1;
			ri_n                  <= 1'b1;
			rate_indicate_n       <= 1'b1;
			autoanswer_lamp_n     <= 1'b1;
			testmode_lamp_n       <= 1'b1;
			terminal_ready_lamp_n <= 1'b1;
		end
		else
		begin
			rxd_n                 <= next_rxd_n;
			cts_n                 <= next_cts_n;
			dsr_n                 <= next_dsr_n;
			line_signal_detect_n  <= next_line_signal_detect_n_n;
			test_mode_n           <= next_tm_n;
			ri_n                  <= next_ri_n;
			rate_indicate_n       <= next_rate_n;
			autoanswer_lamp_n     <= next_aa_n;
			testmode_lamp_n       <= next_tmlamp_n;
			terminal_ready_lamp_n <= next_dtrlamp_n;
		end
	end
endmodule
`default_nettype wire

/* File: dv/dsc_dte_model.sv */
// Purpose: terminal-side partner that drives the control pins
// Assumes: pins change only when the bench calls drive
// Notes:   received data is believed only while set-ready is on
`timescale 1ns/1ps
`default_nettype none
module dsc_dte_model (
	output var logic txd_n,
	output var logic dtr_n,
	output var logic rts_n,
	output var logic remote_loop_req_n,
	output var logic analog_loop_req_n,
	input  wire logic dsr_n,
	input  wire logic rxd_n,
	output logic      heard
);
	initial {txd_n, dtr_n, rts_n, remote_loop_req_n, analog_loop_req_n} = 5'h1F;
	// pins are inverted circuits, so a low bit is ON
	task automatic drive(input logic [4:0] v);
		{txd_n, dtr_n, rts_n, remote_loop_req_n, analog_loop_req_n} = v;
	endtask
	assign heard = dsr_n ? 1'b1 : rxd_n;
endmodule
`default_nettype wire

/* File: dv/dsc_serial_ctrl_assertions.sv */
// Purpose: port-level checks for the terminal-side control block
// Assumes: outputs are registered one edge after their causes, loop requests three edges after their pins
// Notes:   age keeps checks quiet until history is valid
`timescale 1ns/1ps
`default_nettype none
module dsc_serial_ctrl_assertions #(
	parameter int unsigned RATE_W = 17
) (
	input wire logic              clock,
	input wire logic              nrst,
	input wire logic              rxd_n,
	input wire logic              cts_n,
	input wire logic              line_signal_detect_n,
	input wire logic              ri_n,
	input wire logic              rate_indicate_n,
	input wire logic              analog_loop_req_n,
	input wire logic              autoanswer_lamp_n,
	input wire logic [3:0]        flow_control_setting,
	input wire logic              carrier_forced_on_setting,
	input wire logic [7:0]        answer_ring_count,
	input wire logic              sync_mode,
	input wire logic              online,
	input wire logic              resp_data,
	input wire logic              line_rx_data,
	input wire logic              carrier_detect,
	input wire logic              ring_on,
	input wire logic [RATE_W-1:0] line_rate_bps,
	input wire logic              high_rate_wanted,
	input wire logic              host_ready_for_data,
	input wire logic              analog_loop_req
);
	logic [1:0] age;
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			age <= 2'h0;
		else if (age != 2'h3)
			age <= age + 2'h1;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	rx_steer_a: assert property (age != 2'h0 |-> rxd_n ==
		($past(online) ? $past(line_rx_data) : $past(resp_data))) else $error("rxd steering wrong");
	cts_on_a: assert property (age != 2'h0 && !$past(sync_mode) &&
		$past(flow_control_setting) != 4'h3 |-> !cts_n) else $error("cts not held on");
	carrier_det_a: assert property (age != 2'h0 |-> line_signal_detect_n ==
		!($past(carrier_forced_on_setting) || $past(carrier_detect))) else $error("lsd wrong");
	ring_ind_a: assert property (age != 2'h0 |-> ri_n == !$past(ring_on))
		else $error("ring indicate wrong");
	rate_ind_a: assert property (age != 2'h0 |-> rate_indicate_n ==
		!($past(high_rate_wanted) || $past(line_rate_bps) >= 2400)) else $error("rate wrong");
	answer_lamp_a: assert property (age != 2'h0 |->
		autoanswer_lamp_n == ($past(answer_ring_count) == 8'h00)) else $error("aa lamp wrong");
	loop_sync_a: assert property (age == 2'h3 |->
		analog_loop_req == !$past(analog_loop_req_n, 3)) else $error("loop latency wrong");
	rts_cmd_a: assert property (age != 2'h0 && !$past(online) |-> host_ready_for_data)
		else $error("rts used offline");
endmodule
bind dsc_serial_ctrl dsc_serial_ctrl_assertions #(.RATE_W(RATE_W)) u_dsc_chk (.*);
`default_nettype wire

/* File: dv/dte_serial_control_indicators_tb_top.sv */
// Purpose: self-checking bench for the terminal-side control block
// Assumes: lamp flash cut to four cycles
// Notes:   inputs move 2 ns after each rising edge
`timescale 1ns/1ps
`default_nettype none
module dte_serial_control_indicators_tb_top;
	logic        clock, nrst, txd_n, dtr_n, rts_n, remote_loop_req_n, analog_loop_req_n;
	logic        rxd_n, cts_n, dsr_n, line_signal_detect_n, test_mode_n, ri_n, heard;
	logic        rate_indicate_n, autoanswer_lamp_n, testmode_lamp_n, terminal_ready_lamp_n;
	logic        cmd_tx_data, line_tx_data, terminal_ready, host_ready_for_data;
	logic        remote_loop_req, analog_loop_req, disconnect_req, reset_req, cmd_mode_req;
	logic        connection_state, set_ready_setting, carrier_forced_on_setting, sync_mode;
	logic        online, resp_data, line_rx_data, carrier_detect, ring_on, high_rate_wanted;
	logic        data_ready, core_test_active, test_error, host_can_send;
	logic [3:0]  flow_control_setting, operating_mode_setting;
	logic [1:0]  terminal_ready_handling;
	logic [7:0]  answer_ring_count;
	logic [16:0] line_rate_bps;
	logic [2:0]  seen;
	logic [2:0]  expEv [5] = '{3'h0, 3'h4, 3'h1, 3'h3, 3'h1};
	int          nFail, totalChecks, cycles;
	dsc_serial_ctrl #(.FLASH_CYCLES(4)) u_dsc_serial_ctrl (.*);
	dsc_dte_model u_dsc_dte_model (.*);
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			nFail++;
			conclude();
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge clock);
		#2;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		totalChecks++;
		if (got !== exp)
		begin
			nFail++;
			$display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask
	// command-mode and reset requests pulse for one cycle, so every edge is gathered
	task automatic waitEv(input int n);
		seen = 3'h0;
		repeat (n)
		begin
			step(1);
			seen |= {cmd_mode_req, reset_req, disconnect_req};
		end
	endtask
	task automatic conclude();
		$display("checks=%0d errors=%0d", totalChecks, nFail);
		if (nFail == 0 && totalChecks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		nrst = 1'b0;
		{set_ready_setting, carrier_forced_on_setting, sync_mode, online, resp_data} = 5'h00;
		{line_rx_data, carrier_detect, ring_on, high_rate_wanted, data_ready} = 5'h00;
		{core_test_active, test_error, host_can_send} = 3'h0;
		{flow_control_setting, operating_mode_setting} = 8'h00;
		terminal_ready_handling = 2'h2;
		answer_ring_count = 8'h00;
		line_rate_bps = 17'h00000;
		step(5);
		chk({rxd_n, cts_n, dsr_n, ri_n, test_mode_n, testmode_lamp_n}, 6'h3F);
		nrst = 1'b1;
		step(3);
		for (int i = 0; i < 4; i++)
		begin
			{online, resp_data} = i[1:0];
			line_rx_data = !i[0];
			u_dsc_dte_model.drive({i[0], 4'h7});
			step(1);
			chk(rxd_n, i[1] ? !i[0] : i[0]);
			chk({cmd_tx_data, line_tx_data}, i[1] ? {1'b1, i[0]} : {i[0], 1'b1});
		end
		for (int j = 0; j < 4; j++)
		begin
			flow_control_setting = j[1] ? 4'h3 : 4'h0;
			host_can_send = j[0];
			u_dsc_dte_model.drive({2'h2, j[0], 2'h3});
			step(3);
			chk(cts_n, j[1] & !j[0]);
			chk(host_ready_for_data, !j[1] | !j[0]);
		end
		// synchronous operation: rts gates cts and the core's send path
		sync_mode = 1'b1;
		flow_control_setting = 4'h0;
		for (int s = 0; s < 2; s++)
		begin
			u_dsc_dte_model.drive({2'h2, s[0], 2'h3});
			step(3);
			chk({cts_n, host_ready_for_data}, {s[0], !s[0]});
		end
		sync_mode = 1'b0;
		online = 1'b0;
		step(1);
		chk(host_ready_for_data, 1'b1);
		for (int k = 0; k < 4; k++)
		begin
			{carrier_forced_on_setting, carrier_detect} = k[1:0];
			ring_on = k[0];
			high_rate_wanted = k[1] & k[0];
			line_rate_bps = k[1] ? 17'h00960 : 17'h0095F;
			answer_ring_count = k[0] ? 8'hFF : {7'h00, k[1]};
			step(1);
			chk(line_signal_detect_n, k == 0);
			chk(ri_n, !k[0]);
			chk(rate_indicate_n, !k[1]);
			chk(autoanswer_lamp_n, k == 0);
		end
		set_ready_setting = 1'b1;
		step(1);
		chk({dsr_n, heard}, 2'h3);
		data_ready = 1'b1;
		step(1);
		chk(dsr_n, 1'b0);
		for (int h = 0; h < 5; h++)
		begin
			terminal_ready_handling = (h == 4) ? 2'h1 : h[1:0];
			operating_mode_setting = (h == 4) ? 4'h1 : 4'h0;
			u_dsc_dte_model.drive(5'h17);
			online = 1'b1;
			step(6);
			chk({connection_state, terminal_ready_lamp_n, terminal_ready}, 3'h5);
			u_dsc_dte_model.drive(5'h1F);
			waitEv(6);
			chk(seen, expEv[h]);
			chk({connection_state, terminal_ready_lamp_n, terminal_ready}, {!expEv[h][0], h != 0, h == 0});
			online = 1'b0;
			step(2);
		end
		u_dsc_dte_model.drive(5'h1E);
		step(4);
		chk({analog_loop_req, test_mode_n, testmode_lamp_n}, 3'h4);
		test_error = 1'b1;
		step(1);
		test_error = 1'b0;
		step(2);
		chk(testmode_lamp_n, 1'b1);
		step(6);
		chk(testmode_lamp_n, 1'b0);
		u_dsc_dte_model.drive(5'h1D);
		step(4);
		chk({remote_loop_req, analog_loop_req, test_mode_n}, 3'h4);
		u_dsc_dte_model.drive(5'h1F);
		core_test_active = 1'b1;
		step(4);
		chk({remote_loop_req, test_mode_n}, 2'h0);
		core_test_active = 1'b0;
		step(2);
		chk(test_mode_n, 1'b1);
		conclude();
	end
endmodule
`default_nettype wire
